// *** src/ipa_top.sv ***
`timescale 1ns/1ns
`include "ipa_defs.svh"

module ipa_top (
   input  wire logic                     clk_i,
   input  wire logic                     rst_n_i,
   input  wire logic                     ctrl_mode_sel_hi_i,
   input  wire logic                     ctrl_mode_sel_lo_i,
   input  wire logic                     global_mask_i,
   input  wire logic                     user_mask_i,
   input  wire logic [`IPA_PIN_N-1:0]    pin_req_i,
   input  wire logic [`IPA_PIN_N-1:0]    pin_en_i,
   input  wire logic [`IPA_PERIPH_N-1:0] periph_req_i,
   input  wire logic [`IPA_PERIPH_N-1:0] periph_en_i,
   input  wire logic [7:0]               level_sel_reg_a_i,
   input  wire logic [7:0]               level_sel_reg_b_i,
   input  wire logic [7:0]               level_sel_reg_c_i,
   input  wire logic [7:0]               level_sel_reg_d_i,
   input  wire logic                     wdt_nmi_i,
   input  wire logic                     addr_trap_i,
   input  wire logic                     cpu_take_i,
   output logic                          irq_valid_o,
   output logic [7:0]                    vector_num_o,
   output logic [15:0]                   vector_addr_o,
   output logic [`IPA_PIN_N-1:0]         pin_clr_o,
   output logic                          accepted_level_o
);

   ////////////////////////////////////////////////////////////////////////
   // Vector lookup

   function automatic logic [7:0] src_vector(
      input logic [`IPA_IDX_W-1:0] idx
   );
      logic [7:0] wide;
      wide = {3'h0, idx};
      if (wide < 8'(`IPA_PIN_N)) begin
         src_vector = `IPA_PIN_VEC_BASE + wide;
      end else begin
         src_vector = `IPA_PERIPH_VEC_BASE + (wide - 8'(`IPA_PIN_N));
      end
   endfunction : src_vector

   ////////////////////////////////////////////////////////////////////////
   // Request gating and level split

   logic [`IPA_SRC_N-1:0] en_req;
   logic [`IPA_SRC_N-1:0] level_bits;
   logic [`IPA_SRC_N-1:0] req_lvl1;
   logic [`IPA_SRC_N-1:0] req_lvl0;
   logic                  found1;
   logic                  found0;
   logic [`IPA_IDX_W-1:0] idx1;
   logic [`IPA_IDX_W-1:0] idx0;
   logic                  mode1;
   logic                  lvl1_ok;
   logic                  lvl0_ok;

   always_comb begin
      en_req     = {periph_req_i & periph_en_i, pin_req_i & pin_en_i};
      level_bits = {level_sel_reg_d_i, level_sel_reg_c_i,
                    level_sel_reg_b_i, level_sel_reg_a_i};
      req_lvl1   = en_req & level_bits;
      req_lvl0   = en_req & ~level_bits;
   end

   ipa_pri_enc u_enc_lvl1 (
      .req_i   (req_lvl1),
      .found_o (found1),
      .idx_o   (idx1)
   );

   ipa_pri_enc u_enc_lvl0 (
      .req_i   (req_lvl0),
      .found_o (found0),
      .idx_o   (idx0)
   );

   ////////////////////////////////////////////////////////////////////////
   // Mask evaluation

   // Only the exact mode 1 code enables user mask gating
   always_comb begin
      mode1   = ({ctrl_mode_sel_hi_i, ctrl_mode_sel_lo_i}
                 == `IPA_MODE1);
      lvl0_ok = ~global_mask_i;
      lvl1_ok = ~global_mask_i | (mode1 & ~user_mask_i);
   end

   ////////////////////////////////////////////////////////////////////////
   // Candidate selection

   logic                  cand_valid;
   logic [7:0]            cand_vec;
   logic [`IPA_IDX_W-1:0] cand_idx;
   logic                  cand_pin;
   logic                  cand_lvl;
   ipa_pkg::ipa_src_t     cand_src;

   // Masked level 1 requests do not block level 0; the chain falls through to level 0,
   // but a masked level 1 means global_mask_i is set, so level 0 is masked too
   always_comb begin
      cand_valid = 1'b1;
      cand_vec   = `IPA_RST_VEC;
      cand_idx   = `IPA_RST_IDX;
      cand_lvl   = 1'b0;
      cand_src   = ipa_pkg::IPA_SRC_NONE;
      if (wdt_nmi_i) begin
         cand_vec = `IPA_NMI_VEC;
         cand_src = ipa_pkg::IPA_SRC_NMI;
      end else if (addr_trap_i) begin
         cand_vec = `IPA_TRAP_VEC;
         cand_src = ipa_pkg::IPA_SRC_TRAP;
      end else if (found1 && lvl1_ok) begin
         cand_idx = idx1;
         cand_vec = src_vector(idx1);
         cand_lvl = 1'b1;
      end else if (found0 && lvl0_ok) begin
         cand_idx = idx0;
         cand_vec = src_vector(idx0);
      end else begin
         cand_valid = 1'b0;
      end
      if (cand_src == ipa_pkg::IPA_SRC_NONE && cand_valid) begin
         cand_src = ({3'h0, cand_idx} < 8'(`IPA_PIN_N)) ?
                    ipa_pkg::IPA_SRC_PIN : ipa_pkg::IPA_SRC_PERIPH;
      end
      cand_pin = (cand_src == ipa_pkg::IPA_SRC_PIN);
   end

   ////////////////////////////////////////////////////////////////////////
   // Acceptance sequence

   ipa_pkg::ipa_state_t   state;
   ipa_pkg::ipa_state_t   next_state;
   logic [1:0]            cnt;
   logic [1:0]            next_cnt;
   logic                  next_irq_valid;
   logic [7:0]            next_vector_num;
   logic [15:0]           next_vector_addr;
   logic [`IPA_PIN_N-1:0] next_pin_clr;
   logic                  next_accepted_level;
   logic [`IPA_IDX_W-1:0] held_idx;
   logic [`IPA_IDX_W-1:0] next_held_idx;
   logic                  held_pin;
   logic                  next_held_pin;

   always_comb begin
      next_state          = state;
      next_cnt            = cnt;
      next_irq_valid      = irq_valid_o;
      next_vector_num     = vector_num_o;
      next_vector_addr    = vector_addr_o;
      next_pin_clr        = `IPA_RST_PIN_CLR;
      next_accepted_level = accepted_level_o;
      next_held_idx       = held_idx;
      next_held_pin       = held_pin;
      case (state)
         ipa_pkg::IPA_IDLE: begin
            if (cand_valid) begin
               next_state = ipa_pkg::IPA_DECIDE;
               next_cnt   = 2'h1;
            end
         end
         ipa_pkg::IPA_DECIDE: begin
            if (!cand_valid) begin
               next_state = ipa_pkg::IPA_IDLE;
               next_cnt   = `IPA_RST_CNT;
            end else if (cnt == `IPA_PRI_STATES - 2'h1) begin
               next_state = ipa_pkg::IPA_OFFER;
               next_cnt   = `IPA_RST_CNT;
               next_irq_valid = 1'b1;
            end else begin
               next_cnt = cnt + 2'h1;
            end
         end
         ipa_pkg::IPA_OFFER: begin
            if (cpu_take_i) begin
               // Clear goes out with the hand-off of the taken vector
               next_irq_valid = 1'b0;
               next_state     = ipa_pkg::IPA_RETIRE;
               for (int i = 0; i < `IPA_PIN_N; i++) begin
                  next_pin_clr[i] = held_pin &&
                     (held_idx == i[`IPA_IDX_W-1:0]);
               end
            end else if (!cand_valid) begin
               // Request withdrawn or masked before the CPU took it
               next_irq_valid = 1'b0;
               next_state     = ipa_pkg::IPA_IDLE;
            end
         end
         ipa_pkg::IPA_RETIRE: begin
            // One idle cycle lets the cleared pin flag settle
            next_state = ipa_pkg::IPA_IDLE;
         end
         default: begin
            next_state = ipa_pkg::IPA_IDLE;
         end
      endcase
      // While offered, the current winner of any rank replaces the old one each cycle
      if (next_irq_valid && !(state == ipa_pkg::IPA_OFFER && cpu_take_i)) begin
         next_vector_num  = cand_vec;
         next_vector_addr = {8'h00, cand_vec} << `IPA_VEC_ADDR_SHIFT;
         next_accepted_level = cand_lvl;
         next_held_idx    = cand_idx;
         next_held_pin    = cand_pin;
      end
   end

   // CPU side finishes its instruction and raises cpu_take_i, then stacks
   // and sets masks in the cycle after; nothing here waits on it
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state            <= ipa_pkg::IPA_IDLE;
         cnt              <= `IPA_RST_CNT;
         irq_valid_o      <= 1'b0;
         vector_num_o     <= `IPA_RST_VEC;
         vector_addr_o    <= `IPA_RST_ADDR;
         pin_clr_o        <= `IPA_RST_PIN_CLR;
         accepted_level_o <= 1'b0;
         held_idx         <= `IPA_RST_IDX;
         held_pin         <= 1'b0;
      end else begin
         state            <= next_state;
         cnt              <= next_cnt;
         irq_valid_o      <= next_irq_valid;
         vector_num_o     <= next_vector_num;
         vector_addr_o    <= next_vector_addr;
         pin_clr_o        <= next_pin_clr;
         accepted_level_o <= next_accepted_level;
         held_idx         <= next_held_idx;
         held_pin         <= next_held_pin;
      end
   end

endmodule : ipa_top

// *** src/ipa_defs.svh ***
`ifndef IPA_DEFS_SVH
`define IPA_DEFS_SVH

// Source counts and layout of the request vector
`define IPA_PIN_N            6
`define IPA_PERIPH_N         26
`define IPA_SRC_N            32
`define IPA_IDX_W            5

// Vector numbers
`define IPA_PIN_VEC_BASE     8'h15
`define IPA_PERIPH_VEC_BASE  8'h1B
`define IPA_NMI_VEC          8'h07
`define IPA_TRAP_VEC         8'h09

// Vector address is the vector number times four
`define IPA_VEC_ADDR_SHIFT   2

// Control mode encoding for mode 1
`define IPA_MODE1            2'h1

// Priority determination length in clock cycles
`define IPA_PRI_STATES       2'h3

// Reset values
`define IPA_RST_VEC          8'h00
`define IPA_RST_ADDR         16'h0000
`define IPA_RST_PIN_CLR      6'h00
`define IPA_RST_IDX          5'h00
`define IPA_RST_CNT          2'h0

`endif

// *** src/ipa_pkg.sv ***
package ipa_pkg;

   typedef enum logic [1:0] {
      IPA_IDLE,
      IPA_DECIDE,
      IPA_OFFER,
      IPA_RETIRE
   } ipa_state_t;

   typedef enum logic [2:0] {
      IPA_SRC_NONE,
      IPA_SRC_NMI,
      IPA_SRC_TRAP,
      IPA_SRC_PIN,
      IPA_SRC_PERIPH
   } ipa_src_t;

endpackage : ipa_pkg

// *** src/ipa_pri_enc.sv ***
`timescale 1ns/1ns
`include "ipa_defs.svh"

module ipa_pri_enc (
   input  wire logic [`IPA_SRC_N-1:0] req_i,
   output logic                       found_o,
   output logic [`IPA_IDX_W-1:0]      idx_o
);

   // Lowest index ranks highest; scanning downward lets it win last
   always_comb begin
      found_o = 1'b0;
      idx_o   = `IPA_RST_IDX;
      for (int i = `IPA_SRC_N - 1; i >= 0; i--) begin
         if (req_i[i]) begin
            found_o = 1'b1;
            idx_o   = i[`IPA_IDX_W-1:0];
         end
      end
   end

endmodule : ipa_pri_enc

// *** tb/ipa_top_chk.sv ***
`timescale 1ns/1ns
`include "ipa_defs.svh"
module ipa_top_chk (
   input wire logic                  clk_i,
   input wire logic                  rst_n_i,
   input wire logic                  ctrl_mode_sel_hi_i,
   input wire logic                  ctrl_mode_sel_lo_i,
   input wire logic                  global_mask_i,
   input wire logic                  user_mask_i,
   input wire logic                  wdt_nmi_i,
   input wire logic                  addr_trap_i,
   input wire logic                  cpu_take_i,
   input wire logic                  irq_valid_o,
   input wire logic [7:0]            vector_num_o,
   input wire logic [15:0]           vector_addr_o,
   input wire logic [`IPA_PIN_N-1:0] pin_clr_o,
   input wire logic                  accepted_level_o
);
   logic mode1;
   logic urgent;
   assign mode1  = !ctrl_mode_sel_hi_i && ctrl_mode_sel_lo_i;
   assign urgent = wdt_nmi_i || addr_trap_i;
   default clocking dc @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////
   a_addr_pair: assert property (
      irq_valid_o |-> vector_addr_o == {6'h00, vector_num_o, 2'h0})
      else $error("vector address mismatch");
   a_nmi_first: assert property (
      irq_valid_o && $past(wdt_nmi_i) |-> vector_num_o == `IPA_NMI_VEC)
      else $error("watchdog request not offered first");
   a_trap_next: assert property (
      irq_valid_o && $past(addr_trap_i && !wdt_nmi_i)
      |-> vector_num_o == `IPA_TRAP_VEC) else $error("trap not offered");
   a_mode0_mask: assert property (
      irq_valid_o && $past(global_mask_i && !mode1) |-> $past(urgent))
      else $error("masked request offered");
   a_mode1_mask: assert property (
      irq_valid_o && $past(global_mask_i && user_mask_i) |-> $past(urgent))
      else $error("request offered under both masks");
   a_level_one: assert property (
      irq_valid_o && $past(mode1 && global_mask_i && !urgent)
      |-> accepted_level_o) else $error("level zero offered");
   a_take_gap: assert property (
      irq_valid_o && cpu_take_i |=> !irq_valid_o [*4])
      else $error("offer too soon after take");
   a_pin_clear: assert property (
      irq_valid_o && cpu_take_i && vector_num_o inside {[8'h15:8'h1A]}
      |=> pin_clr_o == 6'h01 << ($past(vector_num_o) - 8'h15))
      else $error("wrong pin flag cleared");
   a_clr_once: assert property (
      pin_clr_o != 6'h00 |-> $past(irq_valid_o && cpu_take_i)
      ##1 pin_clr_o == 6'h00) else $error("stray pin clear");
endmodule : ipa_top_chk

bind ipa_top ipa_top_chk chk_u (
   .clk_i(clk_i), .rst_n_i(rst_n_i),
   .ctrl_mode_sel_hi_i(ctrl_mode_sel_hi_i),
   .ctrl_mode_sel_lo_i(ctrl_mode_sel_lo_i),
   .global_mask_i(global_mask_i), .user_mask_i(user_mask_i),
   .wdt_nmi_i(wdt_nmi_i), .addr_trap_i(addr_trap_i),
   .cpu_take_i(cpu_take_i), .irq_valid_o(irq_valid_o),
   .vector_num_o(vector_num_o), .vector_addr_o(vector_addr_o),
   .pin_clr_o(pin_clr_o), .accepted_level_o(accepted_level_o)
);

// *** tb/ipa_cpu_model.sv ***
`timescale 1ns/1ns
module ipa_cpu_model (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        run_i,
   input  wire logic        mode1_i,
   input  wire logic        g_i,
   input  wire logic        u_i,
   input  wire logic [3:0]  stall_i,
   input  wire logic        irq_valid_i,
   input  wire logic [15:0] vector_addr_i,
   output logic             take_o,
   output logic             global_mask_o,
   output logic             user_mask_o,
   output logic [15:0]      handler_o
);
   logic [3:0]  wait_cnt;
   logic        g_set;
   logic        u_set;
   logic [15:0] pc;
   logic [17:0] stack_top;
   assign global_mask_o = g_i | g_set;
   assign user_mask_o   = u_i | u_set;
   ////////////////////////////////////////
   // Run low drops the sticky masks so the bench can reuse the model
   always_ff @(posedge clk_i) begin
      take_o <= 1'b0;
      pc     <= pc + 16'h0002;
      if (!rst_n_i || !run_i) begin
         {wait_cnt, g_set, u_set} <= 6'h00;
         pc        <= 16'h0400;
         handler_o <= 16'h0000;
      end else if (take_o) begin
         stack_top <= {global_mask_o, user_mask_o, pc};
         g_set     <= 1'b1;
         u_set     <= mode1_i;
         handler_o <= vector_addr_i + 16'h1000;
         wait_cnt  <= 4'h0;
      end else if (irq_valid_i && wait_cnt == stall_i) begin
         take_o <= 1'b1;
      end else begin
         wait_cnt <= irq_valid_i ? wait_cnt + 4'h1 : 4'h0;
      end
   end
endmodule : ipa_cpu_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
   logic [39:0] rows [15];
   logic        clk_i = 1'b0, rst_n_i = 1'b0, run = 1'b0;
   logic        g = 1'b0, u = 1'b0, nmi = 1'b0, trp = 1'b0;
   logic [1:0]  md = 2'h0;
   logic [5:0]  pr = 6'h00, pe = 6'h00, clr;
   logic [25:0] qr = 26'h0, qe = 26'h3FFFFFE;
   logic [7:0]  la = 8'h00, vec;
   logic [15:0] addr, hnd;
   logic        take, gm, um, valid, lvl;
   int          num_errors = 0, cmp_count = 0, i;
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   ipa_top dut_u (
      .clk_i(clk_i), .rst_n_i(rst_n_i),
      .ctrl_mode_sel_hi_i(md[1]), .ctrl_mode_sel_lo_i(md[0]),
      .global_mask_i(gm), .user_mask_i(um), .pin_req_i(pr), .pin_en_i(pe),
      .periph_req_i(qr), .periph_en_i(qe),
      .level_sel_reg_a_i(la), .level_sel_reg_b_i(la),
      .level_sel_reg_c_i(la), .level_sel_reg_d_i(la),
      .wdt_nmi_i(nmi), .addr_trap_i(trp), .cpu_take_i(take),
      .irq_valid_o(valid), .vector_num_o(vec), .vector_addr_o(addr),
      .pin_clr_o(clr), .accepted_level_o(lvl));
   ipa_cpu_model cpu_u (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(run), .mode1_i(md == 2'h1),
      .g_i(g), .u_i(u), .stall_i(4'h3), .irq_valid_i(valid),
      .vector_addr_i(addr), .take_o(take), .global_mask_o(gm),
      .user_mask_o(um), .handler_o(hnd));
   ////////////////////////////////////////
   task check(input string nm, input logic [15:0] exp, got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task stop_test();
      $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test
   // Bounded so a design that never offers cannot hang the run
   task wait_take();
      for (int n = 0; n < 50 && take !== 1'b1; n++) @(negedge clk_i);
      if (take !== 1'b1) begin
         check("take", 16'h0001, 16'(take));
         stop_test();
      end
      @(negedge clk_i);
   endtask : wait_take
   ////////////////////////////////////////
   initial begin
      // mode, g u nmi trap, pins, pin enables, periph, levels, v vec lvl
      rows = '{{2'h0,4'h0,6'h04,6'h3F,4'h0,8'h00,1'h1,8'h17,1'h0},
               {2'h0,4'h0,6'h14,6'h3B,4'h0,8'h00,1'h1,8'h19,1'h0},
               {2'h0,4'h0,6'h21,6'h3F,4'h0,8'h20,1'h1,8'h1A,1'h1},
               {2'h0,4'h8,6'h02,6'h3F,4'h0,8'h00,1'h0,8'h00,1'h0},
               {2'h0,4'hA,6'h02,6'h3F,4'h0,8'h00,1'h1,8'h07,1'h0},
               {2'h0,4'h9,6'h00,6'h3F,4'h0,8'h00,1'h1,8'h09,1'h0},
               {2'h0,4'h3,6'h01,6'h3F,4'h0,8'h00,1'h1,8'h07,1'h0},
               {2'h1,4'h8,6'h05,6'h3F,4'h0,8'h04,1'h1,8'h17,1'h1},
               {2'h1,4'h8,6'h01,6'h3F,4'h0,8'h00,1'h0,8'h00,1'h0},
               {2'h1,4'hC,6'h04,6'h3F,4'h0,8'h04,1'h0,8'h00,1'h0},
               {2'h3,4'h8,6'h04,6'h3F,4'h0,8'h04,1'h0,8'h00,1'h0},
               {2'h1,4'h4,6'h01,6'h3F,4'h0,8'h00,1'h1,8'h15,1'h0},
               {2'h0,4'h0,6'h00,6'h3F,4'h1,8'h00,1'h0,8'h00,1'h0},
               {2'h0,4'h0,6'h01,6'h3F,4'h6,8'h80,1'h1,8'h1C,1'h1},
               {2'h1,4'hE,6'h04,6'h3F,4'hC,8'h04,1'h1,8'h07,1'h0}};
      repeat (6) @(negedge clk_i);
      check("reset", 16'h0000, {7'h00, valid, vec});
      rst_n_i = 1'b1;
      for (i = 0; i < 15; i++) begin
         {md, g, u, nmi, trp, pr, pe, qr[3:0], la} = rows[i][39:10];
         repeat (2) @(negedge clk_i);
         check("early", 16'h0000, 16'(valid));
         @(negedge clk_i);
         check("valid", 16'(rows[i][9]), 16'(valid));
         if (rows[i][9]) begin
            check("vector", 16'(rows[i][8:1]), 16'(vec));
            check("address", {6'h00, rows[i][8:1], 2'h0}, addr);
            check("level", 16'(rows[i][0]), 16'(lvl));
         end
         {nmi, trp, pr, qr} = 34'h0;
         repeat (3) @(negedge clk_i);
      end
      {md, g, u, pr, la, run} = {4'h0, 6'h04, 8'h00, 1'h1};
      wait_take();
      check("pin_clear", 16'h0004, 16'(clr));
      check("handler", 16'h105C, hnd);
      check("masks", 16'h0002, {14'h0, gm, um});
      @(negedge clk_i);
      check("clear_end", 16'h0000, 16'(clr));
      repeat (6) @(negedge clk_i);
      check("masked", 16'h0000, 16'(valid));
      nmi = 1'b1;
      wait_take();
      check("nmi_handler", 16'h101C, hnd);
      check("stacked_ccr", 16'h0002, 16'(cpu_u.stack_top[17:16]));
      {nmi, run, pr} = 8'h00;
      @(negedge clk_i);
      {md, run, pr} = {2'h1, 1'h1, 6'h01};
      wait_take();
      check("pin0_clear", 16'h0001, 16'(clr));
      check("masks1", 16'h0003, {14'h0, gm, um});
      pr = 6'h05;
      la = 8'h04;
      repeat (6) @(negedge clk_i);
      check("both_masked", 16'h0000, 16'(valid));
      {run, trp} = 2'h1;
      repeat (4) @(negedge clk_i);
      rst_n_i = 1'b0;
      @(negedge clk_i);
      check("mid_reset", 16'h0000, {2'h0, clr, valid, 7'h00});
      rst_n_i = 1'b1;
      repeat (3) @(negedge clk_i);
      check("trap_offer", 16'h0109, {7'h00, valid, vec});
      stop_test();
   end
endmodule : tb_top
